// ---- fcsw_edge_det.sv ----
`timescale 1ns/1ns
`include "fcsw_map.svh"
module fcsw_edge_det
  import fcsw_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic sample,
  input wire logic level,
  input wire logic enable,
  output logic pulse_r
);
  logic prev_r;
  logic pulse_nxt;

  // =====================================================================
  // edge against the level kept at the previous update
  // a level held high across updates never re-fires
  assign pulse_nxt = sample & level & ~prev_r & enable;

  always_ff @(posedge mclk) begin
    if (rst) begin
      prev_r <= 1'h0;
      pulse_r <= 1'h0;
    end else begin
      pulse_r <= pulse_nxt;
      if (sample) begin
        prev_r <= level;
      end
    end
  end
endmodule

// ---- fcsw_map.svh ----
`ifndef FCSW_MAP_SVH
`define FCSW_MAP_SVH
// =====================================================================
// command word
`define FCSW_CMD_DEFAULT 16'h0005
`define FCSW_CMD_ENERGIZE 0
`define FCSW_CMD_QSTOP_N 2
`define FCSW_CMD_ACK 7
`define FCSW_CMD_VALID 10
`define FCSW_CMD_WDOG 11
`define FCSW_CMD_CUST_HI 15
`define FCSW_CMD_CUST_LO 12
// =====================================================================
// state word
`define FCSW_ST_RESET 16'h0000
`define FCSW_ST_ARMED 0
`define FCSW_ST_MODPERM 1
`define FCSW_ST_RUN 2
`define FCSW_ST_FAULT 3
`define FCSW_ST_RSV4 4
`define FCSW_ST_QSTOP_N 5
`define FCSW_ST_RSV6 6
`define FCSW_ST_WARN 7
`define FCSW_FLAG_W 16
`endif

// ---- fcsw_master.sv ----
`timescale 1ns/1ns
// =====================================================================
// fieldbus master model: one command word and one aux value per update
module fcsw_master
  import fcsw_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic slow,
  input wire logic [1:0] valid_mode,
  output logic pd_update,
  output fcsw_word_type pd_cmd_word,
  output fcsw_word_type pd_aux_word
);
  int seed = 32'h8739;
  logic toggle_r = 1'h0;
  fcsw_word_type w;
  initial begin
    pd_update = 1'h0;
    pd_cmd_word = 16'h0000;
    pd_aux_word = 16'h0000;
  end
  always @(negedge mclk) begin
    if (rst || (slow && ($random(seed) & 3) != 0)) begin
      pd_update <= 1'h0;
      // no update: words are not held, so a stale value cannot pass as fresh
      pd_cmd_word <= ~pd_cmd_word;
      pd_aux_word <= ~pd_aux_word;
    end else begin
      w = 16'($random(seed));
      w[11] = ~toggle_r;
      w[10] = (valid_mode == 2'h0) || (valid_mode == 2'h1 && ($random(seed) & 3) != 0);
      toggle_r <= ~toggle_r;
      pd_update <= 1'h1;
      pd_cmd_word <= w;
      pd_aux_word <= 16'($random(seed));
    end
  end
endmodule

// ---- fcsw_pkg.sv ----
package fcsw_pkg;
  typedef logic [15:0] fcsw_word_type;
  typedef logic [3:0] fcsw_cust_type;
endpackage

// ---- fcsw_status_asm.sv ----
`timescale 1ns/1ns
`include "fcsw_map.svh"
module fcsw_status_asm
  import fcsw_pkg::*;
#(
  parameter int FLAG_W = `FCSW_FLAG_W
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic energize_permit,
  input wire logic quick_stop_req,
  input wire logic fault_active,
  input wire logic warning_active,
  input wire logic modulating,
  input wire logic [FLAG_W-1:0] line_side_ok_flags,
  input wire logic [FLAG_W-1:0] app_side_ok_flags,
  output fcsw_word_type state_word_r
);
  fcsw_word_type state_nxt;
  logic armed_flag;
  logic modulation_permitted;

  // =====================================================================
  // word assembly, refreshed every cycle so any read is current
  assign armed_flag = energize_permit & ~quick_stop_req & ~fault_active;
  assign modulation_permitted = (&line_side_ok_flags) & (&app_side_ok_flags);

  always_comb begin
    state_nxt = `FCSW_ST_RESET;
    state_nxt[`FCSW_ST_ARMED] = armed_flag;
    state_nxt[`FCSW_ST_MODPERM] = modulation_permitted;
    state_nxt[`FCSW_ST_RUN] = modulating;
    state_nxt[`FCSW_ST_FAULT] = fault_active;
    state_nxt[`FCSW_ST_QSTOP_N] = ~quick_stop_req;
    state_nxt[`FCSW_ST_WARN] = warning_active;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_word_r <= `FCSW_ST_RESET;
    end else begin
      state_word_r <= state_nxt;
    end
  end
endmodule

// ---- fcsw_top.sv ----
`timescale 1ns/1ns
`include "fcsw_map.svh"
module fcsw_top
  import fcsw_pkg::*;
#(
  parameter int FLAG_W = `FCSW_FLAG_W
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic pd_update,
  input wire fcsw_word_type pd_cmd_word,
  input wire fcsw_word_type pd_aux_word,
  input wire logic pd_is_modbus,
  input wire logic fb_is_cmd_source,
  input wire logic ack_anywhere_en,
  input wire logic wd_fault_active,
  input wire logic fault_active,
  input wire logic warning_active,
  input wire logic modulating,
  input wire logic [FLAG_W-1:0] line_side_ok_flags,
  input wire logic [FLAG_W-1:0] app_side_ok_flags,
  output fcsw_word_type host_command_word_r,
  output fcsw_word_type aux_value_r,
  output logic wd_toggle_r,
  output logic event_ack_pulse_r,
  output logic energize_permit_r,
  output logic quick_stop_req_r,
  output fcsw_cust_type custom_func_r,
  output fcsw_word_type converter_state_word_r
);
  // =====================================================================
  // held words
  fcsw_word_type held_cmd_r;
  fcsw_word_type held_nxt;
  fcsw_word_type eff_nxt;
  fcsw_word_type aux_nxt;
  fcsw_cust_type cust_nxt;
  logic new_valid;
  logic take_cmd;
  logic take_aux;
  logic wd_nxt;
  logic ack_allowed;
  logic energize_nxt;
  logic qstop_nxt;

  assign new_valid = pd_cmd_word[`FCSW_CMD_VALID];
  assign take_cmd = pd_update & new_valid;
  // modbus links only gate the command word; other values pass on every update
  assign take_aux = pd_update & (new_valid | pd_is_modbus);
  assign held_nxt = take_cmd ? pd_cmd_word : held_cmd_r;
  assign aux_nxt = take_aux ? pd_aux_word : aux_value_r;
  // watchdog bypasses the valid gate so a stale hold cannot mask a dead master
  assign wd_nxt = pd_update ? pd_cmd_word[`FCSW_CMD_WDOG] : wd_toggle_r;

  // =====================================================================
  // effective command word
  always_comb begin
    eff_nxt = held_nxt;
    eff_nxt[`FCSW_CMD_WDOG] = wd_nxt;
    if (wd_fault_active) begin
      eff_nxt = `FCSW_CMD_DEFAULT;
    end
  end

  // =====================================================================
  // command source gating
  assign ack_allowed = fb_is_cmd_source | ack_anywhere_en;
  assign energize_nxt = fb_is_cmd_source & eff_nxt[`FCSW_CMD_ENERGIZE];
  assign qstop_nxt = fb_is_cmd_source & ~eff_nxt[`FCSW_CMD_QSTOP_N];
  // bits 8 and 9 reach only host_command_word_r
  assign cust_nxt = fb_is_cmd_source ?
                    eff_nxt[`FCSW_CMD_CUST_HI:`FCSW_CMD_CUST_LO] : 4'h0;

  always_ff @(posedge mclk) begin
    if (rst) begin
      held_cmd_r <= `FCSW_CMD_DEFAULT;
      host_command_word_r <= `FCSW_CMD_DEFAULT;
      aux_value_r <= 16'h0000;
      wd_toggle_r <= 1'h0;
    end else begin
      held_cmd_r <= held_nxt;
      host_command_word_r <= eff_nxt;
      aux_value_r <= aux_nxt;
      wd_toggle_r <= wd_nxt;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      energize_permit_r <= 1'h0;
      quick_stop_req_r <= 1'h0;
      custom_func_r <= 4'h0;
    end else begin
      energize_permit_r <= energize_nxt;
      quick_stop_req_r <= qstop_nxt;
      custom_func_r <= cust_nxt;
    end
  end

  // =====================================================================
  // acknowledge edge and state word
  fcsw_edge_det u_ack (
    .mclk(mclk),
    .rst(rst),
    .sample(pd_update),
    .level(eff_nxt[`FCSW_CMD_ACK]),
    .enable(ack_allowed),
    .pulse_r(event_ack_pulse_r)
  );

  fcsw_status_asm #(
    .FLAG_W(FLAG_W)
  ) u_state (
    .mclk(mclk),
    .rst(rst),
    .energize_permit(energize_permit_r),
    .quick_stop_req(quick_stop_req_r),
    .fault_active(fault_active),
    .warning_active(warning_active),
    .modulating(modulating),
    .line_side_ok_flags(line_side_ok_flags),
    .app_side_ok_flags(app_side_ok_flags),
    .state_word_r(converter_state_word_r)
  );

  // =====================================================================
  // checks
  logic ack_prev_r;
  always_ff @(posedge mclk) begin
    if (rst) begin
      ack_prev_r <= 1'h0;
    end else if (pd_update) begin
      ack_prev_r <= eff_nxt[`FCSW_CMD_ACK];
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  ack_rise_a: assert property (
    pd_update && eff_nxt[`FCSW_CMD_ACK] && !ack_prev_r && ack_allowed
    |=> event_ack_pulse_r)
    else $error("ack rise without pulse");

  ack_only_edge_a: assert property (
    !(pd_update && eff_nxt[`FCSW_CMD_ACK] && !ack_prev_r)
    |=> !event_ack_pulse_r)
    else $error("ack pulse without rising edge");

  ack_gate_a: assert property (
    !fb_is_cmd_source && !ack_anywhere_en |=> !event_ack_pulse_r)
    else $error("ack pulse from foreign source");

  hold_cmd_a: assert property (
    pd_update && !pd_cmd_word[`FCSW_CMD_VALID] |=> $stable(held_cmd_r))
    else $error("invalid word replaced held word");

  take_cmd_a: assert property (
    pd_update && pd_cmd_word[`FCSW_CMD_VALID] |=> held_cmd_r == $past(pd_cmd_word))
    else $error("valid word not taken");

  aux_modbus_a: assert property (
    pd_update && pd_is_modbus |=> aux_value_r == $past(pd_aux_word))
    else $error("modbus aux value gated");

  aux_hold_a: assert property (
    pd_update && !pd_is_modbus && !pd_cmd_word[`FCSW_CMD_VALID]
    |=> $stable(aux_value_r))
    else $error("aux value not held");

  wdog_fresh_a: assert property (
    pd_update |=> wd_toggle_r == $past(pd_cmd_word[`FCSW_CMD_WDOG]))
    else $error("watchdog bit not fresh");

  wdog_eff_a: assert property (
    !wd_fault_active |=> host_command_word_r[`FCSW_CMD_WDOG] == wd_toggle_r)
    else $error("effective watchdog bit mismatch");

  wd_default_a: assert property (
    wd_fault_active |=> host_command_word_r == `FCSW_CMD_DEFAULT)
    else $error("watchdog fault did not force default");

  init_default_a: assert property (
    $past(rst) && !pd_update |-> host_command_word_r == `FCSW_CMD_DEFAULT)
    else $error("command word not default after reset");

  src_gate_a: assert property (
    !fb_is_cmd_source
    |=> !energize_permit_r && !quick_stop_req_r && custom_func_r == 4'h0)
    else $error("foreign source command leaked");

  custom_a: assert property (
    fb_is_cmd_source
    |=> custom_func_r == $past(eff_nxt[`FCSW_CMD_CUST_HI:`FCSW_CMD_CUST_LO]))
    else $error("custom functions mismatch");

  qstop_a: assert property (
    fb_is_cmd_source |=> quick_stop_req_r == !$past(eff_nxt[`FCSW_CMD_QSTOP_N]))
    else $error("quick stop sense wrong");

  energize_a: assert property (
    !eff_nxt[`FCSW_CMD_ENERGIZE] |=> !energize_permit_r)
    else $error("energize permitted while bit 0 low");

  armed_a: assert property (
    !$past(rst) |-> converter_state_word_r[`FCSW_ST_ARMED] ==
    $past(energize_permit_r && !quick_stop_req_r && !fault_active))
    else $error("armed flag wrong");

  modperm_a: assert property (
    !$past(rst) |-> converter_state_word_r[`FCSW_ST_MODPERM] ==
    $past((&line_side_ok_flags) && (&app_side_ok_flags)))
    else $error("modulation permitted flag wrong");

  live_bits_a: assert property (
    !$past(rst) |->
    converter_state_word_r[`FCSW_ST_RUN] == $past(modulating) &&
    converter_state_word_r[`FCSW_ST_FAULT] == $past(fault_active) &&
    converter_state_word_r[`FCSW_ST_WARN] == $past(warning_active))
    else $error("run fault or warning bit stale");

  qstop_state_a: assert property (
    quick_stop_req_r |=> !converter_state_word_r[`FCSW_ST_QSTOP_N])
    else $error("quick stop not reported inverted");

  reserved_a: assert property (
    converter_state_word_r[15:8] == 8'h00 &&
    !converter_state_word_r[`FCSW_ST_RSV4] &&
    !converter_state_word_r[`FCSW_ST_RSV6])
    else $error("reserved state bits set");

  // =====================================================================
  // checks on holding, edge and state word details
  aux_take_a: assert property (
    pd_update && pd_cmd_word[`FCSW_CMD_VALID]
    |=> aux_value_r == $past(pd_aux_word))
    else $error("valid aux value not taken");

  aux_keep_a: assert property (
    !pd_update |=> $stable(aux_value_r))
    else $error("aux value moved without update");

  cmd_keep_a: assert property (
    !pd_update |=> $stable(held_cmd_r))
    else $error("held word moved without update");

  cmd_modbus_hold_a: assert property (
    pd_update && pd_is_modbus && !pd_cmd_word[`FCSW_CMD_VALID]
    |=> $stable(held_cmd_r))
    else $error("modbus link bypassed command gate");

  eff_held_a: assert property (
    !wd_fault_active
    |=> (host_command_word_r & 16'hF7FF) == (held_cmd_r & 16'hF7FF))
    else $error("effective word differs from held word");

  init_held_a: assert property (
    $past(rst) |-> held_cmd_r == `FCSW_CMD_DEFAULT)
    else $error("held word not default after reset");

  wd_hold_a: assert property (
    !pd_update |=> $stable(wd_toggle_r))
    else $error("watchdog bit moved without update");

  ack_single_a: assert property (
    event_ack_pulse_r |=> !event_ack_pulse_r)
    else $error("ack pulse longer than one cycle");

  ack_low_a: assert property (
    !eff_nxt[`FCSW_CMD_ACK] |=> !event_ack_pulse_r)
    else $error("ack pulse while bit 7 low");

  ack_anywhere_a: assert property (
    pd_update && eff_nxt[`FCSW_CMD_ACK] && !ack_prev_r &&
    !fb_is_cmd_source && ack_anywhere_en
    |=> event_ack_pulse_r)
    else $error("ack lost under ack anywhere option");

  permit_on_a: assert property (
    fb_is_cmd_source && eff_nxt[`FCSW_CMD_ENERGIZE]
    |=> energize_permit_r)
    else $error("energize withheld while bit 0 high");

  armed_fault_a: assert property (
    fault_active |=> !converter_state_word_r[`FCSW_ST_ARMED])
    else $error("armed while fault active");

  modperm_low_a: assert property (
    !((&line_side_ok_flags) && (&app_side_ok_flags))
    |=> !converter_state_word_r[`FCSW_ST_MODPERM])
    else $error("modulation permitted with flag low");

  run_bit_a: assert property (
    !modulating |=> !converter_state_word_r[`FCSW_ST_RUN])
    else $error("run bit set while idle");

  fault_bit_a: assert property (
    fault_active |=> converter_state_word_r[`FCSW_ST_FAULT])
    else $error("fault bit missing");

  warn_bit_a: assert property (
    warning_active |=> converter_state_word_r[`FCSW_ST_WARN])
    else $error("warning bit missing");

  qstop_off_a: assert property (
    !quick_stop_req_r |=> converter_state_word_r[`FCSW_ST_QSTOP_N])
    else $error("quick stop bit low while inactive");

  state_live_a: assert property (
    !pd_update && $changed(fault_active)
    |=> converter_state_word_r[`FCSW_ST_FAULT] == $past(fault_active))
    else $error("state word waits for an update");

  take_valid_c: cover property (
    pd_update && pd_cmd_word[`FCSW_CMD_VALID] ##1 pd_update && !pd_cmd_word[`FCSW_CMD_VALID]);

  ack_pulse_c: cover property (event_ack_pulse_r);

  ack_anywhere_c: cover property (event_ack_pulse_r && !$past(fb_is_cmd_source));

  wd_fault_c: cover property (wd_fault_active ##1 !wd_fault_active);
  modbus_gate_c: cover property (pd_update && pd_is_modbus && !pd_cmd_word[`FCSW_CMD_VALID]);
endmodule

// ---- tb_top.sv ----
`timescale 1ns/1ns
module tb_top;
  import fcsw_pkg::*;
  logic mclk = 1'h0;
  logic rst = 1'h1;
  logic slow = 1'h0;
  logic [1:0] vmode = 2'h0;
  logic pd_update;
  fcsw_word_type pd_cmd_word, pd_aux_word;
  logic mb = 1'h0, fb = 1'h0, anyen = 1'h0, wdf = 1'h0;
  logic flt = 1'h0, warn = 1'h0, modu = 1'h0;
  logic [15:0] line_f = 16'h0000, app_f = 16'h0000;
  fcsw_word_type cmd_o, aux_o, st_o;
  logic wd_o, ack_o, perm_o, qs_o;
  fcsw_cust_type cust_o;
  int seed = 32'h8739;
  int n_mismatch = 0;
  int checks = 0;
  logic cmp_on = 1'h0;
  logic [6:0] cfg [7] = '{7'h20, 7'h25, 7'h61, 7'h29, 7'h11, 7'h05, 7'h22};
  // model state
  fcsw_word_type held, eff, m_cmd, m_aux, m_st;
  logic m_wd, m_ack, prev7, m_perm, m_qs;
  logic [3:0] m_cust;

  initial begin
    forever #5 mclk = ~mclk;
  end

  fcsw_master far_end (.mclk(mclk), .rst(rst), .slow(slow), .valid_mode(vmode),
    .pd_update(pd_update), .pd_cmd_word(pd_cmd_word), .pd_aux_word(pd_aux_word));

  fcsw_top uut (.mclk(mclk), .rst(rst), .pd_update(pd_update), .pd_cmd_word(pd_cmd_word),
    .pd_aux_word(pd_aux_word), .pd_is_modbus(mb), .fb_is_cmd_source(fb),
    .ack_anywhere_en(anyen), .wd_fault_active(wdf), .fault_active(flt),
    .warning_active(warn), .modulating(modu), .line_side_ok_flags(line_f),
    .app_side_ok_flags(app_f), .host_command_word_r(cmd_o), .aux_value_r(aux_o),
    .wd_toggle_r(wd_o), .event_ack_pulse_r(ack_o), .energize_permit_r(perm_o),
    .quick_stop_req_r(qs_o), .custom_func_r(cust_o), .converter_state_word_r(st_o));

  // =====================================================================
  // reference model, one step per clock edge
  always @(posedge mclk) begin
    if (rst) begin
      held = 16'h0005;
      {m_cmd, m_aux, m_st} = {16'h0005, 32'h0};
      {m_wd, m_ack, prev7, m_perm, m_qs, m_cust} = 9'h000;
    end else begin
      m_st = {8'h00, warn, 1'h0, ~m_qs, 1'h0, flt, modu, &{line_f, app_f},
        m_perm & ~m_qs & ~flt};
      if (pd_update && pd_cmd_word[10]) held = pd_cmd_word;
      if (pd_update && (pd_cmd_word[10] || mb)) m_aux = pd_aux_word;
      if (pd_update) m_wd = pd_cmd_word[11];
      // the watchdog bit is always the fresh one unless the fault forces the default
      eff = wdf ? 16'h0005 : {held[15:12], m_wd, held[10:0]};
      m_cmd = eff;
      m_ack = pd_update && eff[7] && !prev7 && (fb || anyen);
      if (pd_update) prev7 = eff[7];
      m_perm = fb & eff[0];
      m_qs = fb & ~eff[2];
      m_cust = fb ? eff[15:12] : 4'h0;
    end
  end

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  always @(negedge mclk) begin
    if (cmp_on) begin
      chk("cmd", cmd_o, m_cmd);
      chk("aux", aux_o, m_aux);
      chk("wd", {15'h0000, wd_o}, {15'h0000, m_wd});
      chk("ack", {15'h0000, ack_o}, {15'h0000, m_ack});
      chk("permit", {15'h0000, perm_o}, {15'h0000, m_perm});
      chk("qstop", {15'h0000, qs_o}, {15'h0000, m_qs});
      chk("cust", {12'h000, cust_o}, {12'h000, m_cust});
      chk("state", st_o, m_st);
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // =====================================================================
  // phases: {modbus, fb source, ack anywhere, wd fault, slow, valid mode}
  initial begin
    for (int i = 0; i < 7; i++) begin
      @(negedge mclk);
      if (i == 0 || i == 6) begin
        rst = 1'h1;
        repeat (16) @(negedge mclk);
        rst = 1'h0;
        cmp_on = 1'h1;
      end
      {mb, fb, anyen} = cfg[i][6:4];
      slow = cfg[i][2];
      vmode = cfg[i][1:0];
      repeat (300) @(negedge mclk) begin
        wdf = cfg[i][3] && (($random(seed) & 3) == 0);
        {flt, warn, modu} = 3'($random(seed));
        line_f = ($random(seed) & 1) ? 16'hFFFF : 16'($random(seed));
        app_f = ($random(seed) & 1) ? 16'hFFFF : 16'($random(seed));
      end
      $display("phase %0d done", i);
    end
    @(negedge mclk);
    give_verdict();
  end
endmodule
